// >>> isscc_regs.svh
/*
 register map, field positions, reset values and timing floors of the
 two-wire stop/stretch/clock control block.
 assumes: included by bare name from the design module and the testbench.
*/
`ifndef ISSCC_REGS_SVH
`define ISSCC_REGS_SVH

`define ISSCC_CTRL_ADDR 8'h0C
`define ISSCC_CLK_ADDR 8'h0D
`define ISSCC_STAT_ADDR 8'h10
`define ISSCC_MASK_ADDR 8'h11

`define ISSCC_EN 0
`define ISSCC_MST 1
`define ISSCC_MODE 2
`define ISSCC_STRS 4
`define ISSCC_ACK 5
`define ISSCC_START 6
`define ISSCC_STOP 7
`define ISSCC_GCEN 8
`define ISSCC_STREN 9
`define ISSCC_ABORT 15

`define ISSCC_CFG_MASK 16'h0335
`define ISSCC_CTRL_RESET 16'h0000
`define ISSCC_CLK_RESET 16'h0204
`define ISSCC_MIN_LOW 8'h04
`define ISSCC_MIN_HIGH 8'h02
`define ISSCC_GC_ADDR 8'h00

`define ISSCC_EV_STOP 0
`define ISSCC_EV_TIMEOUT 1
`define ISSCC_EV_GCALL 2
`define ISSCC_EV_STRETCH 3
`define ISSCC_EV_ABORT 4
`define ISSCC_EV_START 5
`define ISSCC_NEV 6

`endif

// >>> isscc_pkg.sv
/*
 types of the two-wire stop/stretch/clock control block.
 assumes: compiled before the design module.
*/
package isscc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_LOW = 3'h3,
        ST_HIGH = 3'h2,
        ST_STOP_SETUP = 3'h6,
        ST_STOP_FREE = 3'h7
    } isscc_state_t;
endpackage : isscc_pkg

// >>> isscc_ctrl.sv
/*
 control part of a two-wire bus controller: stop generation, start/stop
 checking, timeout, general call response, clock stretching, abort and
 scl low/high timing, with register port and interrupt.
 assumes: open-drain scl/sda resolved outside; timeout limit, address
 match and arbitration loss come from neighbouring logic on clk.
*/
// Design decision made here: the strobed register port.
// Behaviour
// - a stop request makes a stop condition, then the request clears itself
// - in master mode a stop request restarts the timeout timer if enabled
// - timeout before the stop raises the timeout event and clears the request
// - stop request does nothing in slave mode, forced low without master/enable
// - stop written while start pending is ignored and stays low
// - general call address zero answered only when its enable is set
// - stretch enable holds scl low at the selected clock end, else never
// - control register bits 14 to 10 read zero
// - abort reset aborts and resets; only hardware clears it
// - clock register resets to 0204h
// - clock register writable only while no transfer is active
// - scl low lasts low count plus one system clocks
// - master low count below four acts as four
// - scl high lasts high count plus one system clocks
// - master high count below two acts as two
// - in slave mode the clock register is unused and no clock is generated
// - stretch select one holds after the 8th fall, zero after the 9th
// - master select cleared on address match, arbitration loss, general call
`timescale 1ns/1ns
`include "isscc_regs.svh"

module isscc_ctrl
    import isscc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [7:0] timeout_limit,
    input wire logic address_match_flag,
    input wire logic arbitration_lost_flag,
    output logic transfer_active,
    output logic irq
);
    logic [15:0] cfg;
    logic master_select, start_request, stop_request, abort_reset;
    logic [15:0] scl_timing_control;
    logic [`ISSCC_NEV-1:0] stat, mask;
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    isscc_state_t st;
    logic [7:0] cnt;
    logic eng_scl_low, eng_sda_low;
    logic [8:0] per_cnt;
    logic [7:0] to_bits;
    logic [3:0] rises;
    logic [7:0] shreg;
    logic first_byte, gc_ack, stretch_hold;
    logic [7:0] low_run, high_run;

    // floors only apply when this end generates the clock
    function automatic logic [7:0] isscc_floor(input logic [7:0] v, input logic [7:0] m,
                                               input logic is_mst);
        isscc_floor = (is_mst && v < m) ? m : v;
    endfunction : isscc_floor

    wire controller_enable = cfg[`ISSCC_EN];
    wire ctrl_wr = reg_wr && reg_addr == `ISSCC_CTRL_ADDR;
    wire run = controller_enable && master_select && !abort_reset;
    wire [7:0] lo_eff = isscc_floor(scl_timing_control[7:0], `ISSCC_MIN_LOW, master_select);
    wire [7:0] hi_eff = isscc_floor(scl_timing_control[15:8], `ISSCC_MIN_HIGH, master_select);
    wire [8:0] per_len = {1'b0, lo_eff} + {1'b0, hi_eff} + 9'h002;

    // pins are foreign to clk; only the second and third stages feed logic
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    wire scl_rise = scl_s2 && !scl_s3;
    wire scl_fall = !scl_s2 && scl_s3;
    wire bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    wire bus_stop = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

    wire start_done = run && st == ST_START && cnt == hi_eff;
    wire stop_done = run && st == ST_STOP_FREE && cnt == hi_eff;
    wire timer_on = run && timeout_limit != 8'h00 && (start_request || stop_request);
    wire timeout_evt = timer_on && per_cnt == per_len - 9'h001 && to_bits == timeout_limit;
    wire stop_take = ctrl_wr && reg_wdata[`ISSCC_STOP] && !reg_wdata[`ISSCC_START]
                     && !start_request && controller_enable && master_select;
    wire start_take = ctrl_wr && reg_wdata[`ISSCC_START] && !reg_wdata[`ISSCC_STOP]
                      && !stop_request && controller_enable && master_select;
    wire stretch_pt = scl_fall && cfg[`ISSCC_STREN]
                      && rises == (cfg[`ISSCC_STRS] ? 4'h8 : 4'h9);
    wire gc_evt = scl_fall && rises == 4'h8 && first_byte && !master_select
                  && shreg == `ISSCC_GC_ADDR && cfg[`ISSCC_GCEN];
    wire abort_done = abort_reset && controller_enable;

    // plain configuration bits; ack forced to nack during abort
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg <= `ISSCC_CTRL_RESET;
        end else if (ctrl_wr) begin
            cfg <= reg_wdata & `ISSCC_CFG_MASK;
            if (abort_reset) begin
                cfg[`ISSCC_ACK] <= 1'b1;
            end
        end else if (abort_reset) begin
            cfg[`ISSCC_ACK] <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            master_select <= 1'b0;
        end else if (address_match_flag || arbitration_lost_flag || gc_evt) begin
            master_select <= 1'b0;
        end else if (ctrl_wr) begin
            master_select <= reg_wdata[`ISSCC_MST];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_request <= 1'b0;
        end else if (!controller_enable || !master_select || abort_reset) begin
            start_request <= 1'b0;
        end else if (start_done || timeout_evt) begin
            start_request <= 1'b0;
        end else if (start_take) begin
            start_request <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stop_request <= 1'b0;
        end else if (!controller_enable || !master_select) begin
            stop_request <= 1'b0;
        end else if (stop_done || timeout_evt || abort_reset) begin
            stop_request <= 1'b0;
        end else if (stop_take) begin
            stop_request <= 1'b1;
        end
    end

    // abort is a one-cycle reset of the engine, then self-clears
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            abort_reset <= 1'b0;
        end else if (!controller_enable || abort_reset) begin
            abort_reset <= 1'b0;
        end else if (ctrl_wr && reg_wdata[`ISSCC_ABORT]) begin
            abort_reset <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_timing_control <= `ISSCC_CLK_RESET;
        end else if (reg_wr && reg_addr == `ISSCC_CLK_ADDR && !transfer_active) begin
            scl_timing_control <= reg_wdata;
        end
    end

    // master clock engine; idles whenever not master
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= ST_IDLE;
            cnt <= 8'h00;
            eng_scl_low <= 1'b0;
            eng_sda_low <= 1'b0;
        end else if (!run || timeout_evt) begin
            st <= ST_IDLE;
            cnt <= 8'h00;
            eng_scl_low <= 1'b0;
            eng_sda_low <= 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (start_request) begin
                        eng_sda_low <= 1'b1;
                        cnt <= 8'h00;
                        st <= ST_START;
                    end
                end
                ST_START: begin
                    if (cnt == hi_eff) begin
                        eng_scl_low <= 1'b1;
                        cnt <= 8'h00;
                        st <= ST_LOW;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_LOW: begin
                    eng_sda_low <= stop_request;
                    if (stretch_hold) begin
                        cnt <= cnt;
                    end else if (cnt == lo_eff) begin
                        eng_scl_low <= 1'b0;
                        cnt <= 8'h00;
                        st <= (stop_request && eng_sda_low) ? ST_STOP_SETUP : ST_HIGH;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_HIGH: begin
                    // far end may hold scl low; count only once it is high
                    // two sync stages have passed by then, so stop two short
                    if (scl_s2) begin
                        if (cnt == hi_eff - 8'h02) begin
                            eng_scl_low <= 1'b1;
                            cnt <= 8'h00;
                            st <= ST_LOW;
                        end else begin
                            cnt <= cnt + 8'h01;
                        end
                    end
                end
                ST_STOP_SETUP: begin
                    if (scl_s2) begin
                        if (cnt == hi_eff) begin
                            eng_sda_low <= 1'b0;
                            cnt <= 8'h00;
                            st <= ST_STOP_FREE;
                        end else begin
                            cnt <= cnt + 8'h01;
                        end
                    end
                end
                ST_STOP_FREE: begin
                    if (cnt == hi_eff) begin
                        st <= ST_IDLE;
                        cnt <= 8'h00;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                    cnt <= 8'h00;
                end
            endcase
        end
    end

    // timeout in bit periods; restarts on each scl fall and new request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            per_cnt <= 9'h000;
            to_bits <= 8'h00;
        end else if (!timer_on || scl_fall || stop_take || start_take) begin
            per_cnt <= 9'h000;
            to_bits <= 8'h00;
        end else if (per_cnt == per_len - 9'h001) begin
            per_cnt <= 9'h000;
            to_bits <= to_bits + 8'h01;
        end else begin
            per_cnt <= per_cnt + 9'h001;
        end
    end

    // bus watcher: clock count per byte and first-byte capture
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rises <= 4'h0;
            shreg <= 8'h00;
            first_byte <= 1'b0;
        end else if (!controller_enable || abort_reset) begin
            rises <= 4'h0;
            first_byte <= 1'b0;
        end else if (bus_start) begin
            rises <= 4'h0;
            first_byte <= 1'b1;
        end else begin
            if (scl_rise) begin
                rises <= (rises == 4'h9) ? 4'h1 : rises + 4'h1;
                if (rises != 4'h8) begin
                    shreg <= {shreg[6:0], sda_s2};
                end
            end
            if (scl_fall && rises == 4'h9) begin
                first_byte <= 1'b0;
            end
        end
    end

    // acknowledge the general call through the 9th clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gc_ack <= 1'b0;
        end else if (!controller_enable || abort_reset || bus_stop) begin
            gc_ack <= 1'b0;
        end else if (gc_evt) begin
            gc_ack <= 1'b1;
        end else if (scl_fall && rises == 4'h9) begin
            gc_ack <= 1'b0;
        end
    end

    // released by any control write, so software must service it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stretch_hold <= 1'b0;
        end else if (stretch_pt) begin
            stretch_hold <= 1'b1;
        end else if (ctrl_wr || !cfg[`ISSCC_STREN] || !controller_enable || abort_reset) begin
            stretch_hold <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            transfer_active <= 1'b0;
        end else if (!controller_enable || abort_reset || stop_done || timeout_evt) begin
            transfer_active <= 1'b0;
        end else if ((st == ST_IDLE && start_request && run) || bus_start) begin
            transfer_active <= 1'b1;
        end else if (bus_stop && !master_select) begin
            transfer_active <= 1'b0;
        end
    end

    wire [`ISSCC_NEV-1:0] events = {start_done, abort_done, stretch_pt, gc_evt,
                                    timeout_evt, stop_done};
    wire stat_wr = reg_wr && reg_addr == `ISSCC_STAT_ADDR;

    // new events win over a same-cycle write-one clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat <= '0;
        end else begin
            stat <= (stat & ~(stat_wr ? reg_wdata[`ISSCC_NEV-1:0] : '0)) | events;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask <= '0;
        end else if (reg_wr && reg_addr == `ISSCC_MASK_ADDR) begin
            mask <= reg_wdata[`ISSCC_NEV-1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `ISSCC_CTRL_ADDR: reg_rdata <= {abort_reset, 5'h00, cfg[9:8], stop_request,
                    start_request, cfg[5:4], 1'b0, cfg[2], master_select, cfg[0]};
                `ISSCC_CLK_ADDR: reg_rdata <= scl_timing_control;
                `ISSCC_STAT_ADDR: reg_rdata <= {transfer_active, 9'h000, stat};
                `ISSCC_MASK_ADDR: reg_rdata <= {10'h000, mask};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    assign irq = |(stat & mask);
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = eng_scl_low || stretch_hold;
    assign sda_oe = eng_sda_low || gc_ack;

    // helper run lengths of the low and high phases
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_run <= 8'h00;
            high_run <= 8'h00;
        end else begin
            low_run <= (st == ST_LOW) ? low_run + {7'h00, !stretch_hold} : 8'h00;
            // wire high time from release; sync lag credited as two
            high_run <= (st == ST_HIGH) ? (scl_s2 ? high_run + 8'h01 : 8'h02) : 8'h00;
        end
    end

    property p_stop_forced;
        @(posedge clk) disable iff (sys_rst)
        !(controller_enable && master_select) |=> !stop_request;
    endproperty
    a_stop_forced: assert property (p_stop_forced) else $error("stop request kept");

    property p_stop_refused;
        @(posedge clk) disable iff (sys_rst)
        (ctrl_wr && reg_wdata[`ISSCC_STOP] && start_request && !stop_request)
        |=> !stop_request;
    endproperty
    a_stop_refused: assert property (p_stop_refused) else $error("stop taken");

    property p_stop_clears;
        @(posedge clk) disable iff (sys_rst)
        stop_done |=> !stop_request && !transfer_active ##1 !scl_oe;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop not cleared");

    property p_timeout_clears;
        @(posedge clk) disable iff (sys_rst)
        timeout_evt |=> !stop_request && stat[`ISSCC_EV_TIMEOUT] && st == ST_IDLE;
    endproperty
    a_timeout_clears: assert property (p_timeout_clears) else $error("timeout lost");

    property p_clk_locked;
        @(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == `ISSCC_CLK_ADDR && transfer_active)
        |=> $stable(scl_timing_control);
    endproperty
    a_clk_locked: assert property (p_clk_locked) else $error("clock reg written");

    property p_low_time;
        @(posedge clk) disable iff (sys_rst)
        (st == ST_LOW && eng_scl_low) ##1 (st == ST_HIGH)
        |-> $past(low_run) == $past(lo_eff) && $past(lo_eff) >= `ISSCC_MIN_LOW;
    endproperty
    a_low_time: assert property (p_low_time) else $error("scl low time wrong");

    property p_high_time;
        @(posedge clk) disable iff (sys_rst)
        (st == ST_HIGH) ##1 (st == ST_LOW)
        |-> $past(high_run) == $past(hi_eff) && $past(hi_eff) >= `ISSCC_MIN_HIGH;
    endproperty
    a_high_time: assert property (p_high_time) else $error("scl high time wrong");

    property p_master_drop;
        @(posedge clk) disable iff (sys_rst)
        (address_match_flag || arbitration_lost_flag || gc_evt) |=> !master_select;
    endproperty
    a_master_drop: assert property (p_master_drop) else $error("master kept");

    property p_abort_short;
        @(posedge clk) disable iff (sys_rst)
        abort_reset |=> !abort_reset && !transfer_active && st == ST_IDLE;
    endproperty
    a_abort_short: assert property (p_abort_short) else $error("abort stuck");

    property p_stretch_hold;
        @(posedge clk) disable iff (sys_rst)
        stretch_pt |=> scl_oe;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) else $error("no stretch");

    property p_gc_gated;
        @(posedge clk) disable iff (sys_rst)
        gc_evt |-> cfg[`ISSCC_GCEN] ##1 sda_oe;
    endproperty
    a_gc_gated: assert property (p_gc_gated) else $error("general call gating");

    property p_slave_quiet;
        @(posedge clk) disable iff (sys_rst)
        !master_select |=> st == ST_IDLE && !eng_scl_low;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives clock");
endmodule : isscc_ctrl

// >>> isscc_peer.sv
/*
 remote two-wire master: start, one byte with ack clock, stop, scl hold.
 assumes: wires pulled up outside; 64 ns bit clock, stands still between frames.
*/
`timescale 1ns/1ns
module isscc_peer (
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // hold scl low, as a slow far side would
    task automatic hold(input logic v);
        scl_low = v;
    endtask : hold
    // remote master owns scl in slave mode
    task automatic send(input logic [7:0] b);
        sda_low = 1'b1;
        #32 scl_low = 1'b1;
        for (int i = 0; i < 9; i++) begin
            sda_low = (i < 8) ? ~b[7 - i] : 1'b0;
            #32 scl_low = 1'b0;
            #32 scl_low = 1'b1;
        end
    endtask : send
    task automatic stop();
        sda_low = 1'b1;
        #32 scl_low = 1'b0;
        #32 sda_low = 1'b0;
    endtask : stop
endmodule : isscc_peer

// >>> isscc_tb.sv
/*
 register-level testbench of the stop/stretch/clock control block.
 assumes: remote master model on scl/sda, wires pulled up here.
*/
`timescale 1ns/1ns
`include "isscc_regs.svh"
module testbench;
    import isscc_pkg::*;
    localparam logic [7:0] ct = `ISSCC_CTRL_ADDR;
    localparam logic [7:0] ck = `ISSCC_CLK_ADDR;
    localparam logic [7:0] st = `ISSCC_STAT_ADDR;
    localparam logic [7:0] mk = `ISSCC_MASK_ADDR;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] timeout_limit = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, rd;
    logic scl_oe, sda_oe, transfer_active, irq, peer_scl, peer_sda;
    logic address_match_flag = 1'b0;
    logic arbitration_lost_flag = 1'b0;
    logic [15:0] modes [4] = '{16'h0001, 16'h0101, 16'h0201, 16'h0211};
    int mismatches = 0;
    int compares = 0;
    int n, w, hw;
    int seen_rises = 0;
    wire scl_w = ~(scl_oe | peer_scl);
    wire sda_w = ~(sda_oe | peer_sda);
    always @(posedge scl_w) seen_rises++;
    always #4 clk = ~clk;
    isscc_ctrl i_isscc_ctrl (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
        .sda_oe(sda_oe), .timeout_limit(timeout_limit),
        .address_match_flag(address_match_flag),
        .arbitration_lost_flag(arbitration_lost_flag),
        .transfer_active(transfer_active), .irq(irq));
    isscc_peer i_isscc_peer (.scl_low(peer_scl), .sda_low(peer_sda));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rdr
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        n = 0;
        do begin
            rdr(a);
            n++;
        end while (rd[b] !== v && n < 300);
        check(16'(rd[b]), 16'(v));
    endtask : poll
    // widths of one scl low phase and the high phase after it
    task automatic low_width();
        n = 0;
        while (scl_oe !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        while (scl_oe !== 1'b1 && n < 600) begin
            @(posedge clk);
            #1 n++;
        end
        w = 0;
        while (scl_oe === 1'b1 && w < 300) begin
            @(posedge clk);
            #1 w++;
        end
        hw = 0;
        while (scl_oe === 1'b0 && hw < 300) begin
            @(posedge clk);
            #1 hw++;
        end
    endtask : low_width
    task automatic give_verdict();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rdr(ck);
        check(rd, 16'h0204);
        wr(ct, 16'h7C01);
        rdr(ct);
        check(16'(rd[14:10]), 16'h0000);
        wr(ct, 16'h0081);
        rdr(ct);
        check(16'(rd[7]), 16'h0000);
        // floors: low 1 acts as 4, high 1 acts as 2
        wr(ck, 16'h0101);
        rdr(ck);
        check(rd, 16'h0101);
        wr(ct, 16'h0003);
        wr(ct, 16'h0043);
        wr(ct, 16'h00C3);
        rdr(ct);
        check(16'(rd[7]), 16'h0000);
        poll(ct, `ISSCC_START, 1'b0);
        check(16'(transfer_active), 16'h0001);
        wr(ck, 16'h0909);
        rdr(ck);
        check(rd, 16'h0101);
        low_width();
        check(16'(w), 16'h0005);
        check(16'(hw), 16'h0003);
        wr(mk, 16'h0001);
        wr(ct, 16'h0083);
        poll(st, 15, 1'b0);
        rdr(ct);
        check(16'(rd[7]), 16'h0000);
        check(16'(irq), 16'h0001);
        wr(st, 16'h0001);
        @(negedge clk);
        check(16'(irq), 16'h0000);
        // stop stuck behind a held scl must time out
        @(posedge clk);
        timeout_limit <= 8'h02;
        wr(ct, 16'h0043);
        poll(ct, `ISSCC_START, 1'b0);
        i_isscc_peer.hold(1'b1);
        wr(ct, 16'h0083);
        poll(st, `ISSCC_EV_TIMEOUT, 1'b1);
        check(16'({scl_oe, sda_oe}), 16'h0000);
        rdr(ct);
        check(16'(rd[7]), 16'h0000);
        i_isscc_peer.hold(1'b0);
        @(posedge clk);
        timeout_limit <= 8'h00;
        wr(st, 16'h003F);
        wr(ct, 16'h0043);
        poll(ct, `ISSCC_START, 1'b0);
        wr(ct, 16'h8003);
        poll(ct, `ISSCC_ABORT, 1'b0);
        rdr(st);
        check(rd & 16'h8010, 16'h0010);
        for (int k = 0; k < 2; k++) begin
            wr(ct, 16'h0003);
            address_match_flag <= (k == 0);
            arbitration_lost_flag <= (k == 1);
            @(posedge clk);
            address_match_flag <= 1'b0;
            arbitration_lost_flag <= 1'b0;
            rdr(ct);
            check(16'(rd[1]), 16'h0000);
        end
        // slave: general call and stretch point, each mode once
        wr(st, 16'h003F);
        for (int k = 0; k < 4; k++) begin
            wr(ct, modes[k]);
            w = seen_rises;
            // peer moves off the clock edge; its pins are foreign to clk
            #3 i_isscc_peer.send(8'h00);
            #40;
            check(16'(scl_oe), 16'(modes[k][9]));
            check(16'(seen_rises - w), modes[k][4] ? 16'h0008 : 16'h0009);
            rdr(st);
            check(16'(rd[3:2]), 16'({modes[k][9], modes[k][8]}));
            wr(ct, 16'h0001);
            #3 i_isscc_peer.stop();
            wr(st, 16'h003F);
        end
        give_verdict();
    end
endmodule : testbench
